// ==== include/sss_pkg.sv ====
// Package for the pipelined synchronous SRAM sleep and cycle controller.
// Assumes a single 20 MHz system clock and a small behavioural array.
package sss_pkg;

  // Address and data widths of the modelled array.
  localparam int ADDR_W = 6;
  localparam int DATA_W = 8;
  localparam int DEPTH  = 64;

  // Clock period in nanoseconds and the sleep timing windows.
  localparam int CLOCK_PERIOD_NS = 50;
  localparam int SLEEP_ENTRY_INPUT_DELAY_NS = CLOCK_PERIOD_NS;
  localparam int SLEEP_EXIT_RECOVERY_WINDOW_NS = CLOCK_PERIOD_NS;
  // Longest times round down; never below one cycle.
  localparam int SLEEP_ENTRY_CYC =
    (SLEEP_ENTRY_INPUT_DELAY_NS / CLOCK_PERIOD_NS) < 1 ? 1 :
    (SLEEP_ENTRY_INPUT_DELAY_NS / CLOCK_PERIOD_NS);
  localparam int SLEEP_EXIT_CYC =
    (SLEEP_EXIT_RECOVERY_WINDOW_NS / CLOCK_PERIOD_NS) < 1 ? 1 :
    (SLEEP_EXIT_RECOVERY_WINDOW_NS / CLOCK_PERIOD_NS);

  // Burst order encodings on the burst-order select pin.
  localparam logic BURST_LINEAR      = 1'h0;
  localparam logic BURST_INTERLEAVED = 1'h1;

  // Reset values of the pipeline.
  localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_RST = 6'h00;
  localparam logic [1:0]        BCNT_RST = 2'h0;

  // Pipeline operation codes.
  typedef enum logic [1:0] {
    SSS_OP_IDLE  = 2'b00,
    SSS_OP_READ  = 2'b01,
    SSS_OP_WRITE = 2'b10
  } sss_op_t;

  // Request from the memory controller.
  typedef struct packed {
    logic              select_low;        // Main active-low select.
    logic              extra_select_low;  // Extra active-low select.
    logic              extra_select_high; // Extra active-high select.
    logic              advance_or_load;   // High advances, low loads.
    logic              read_not_write;    // High reads, low writes.
    logic [ADDR_W-1:0] addr;              // Load address.
  } sss_req_t;

endpackage

// ==== verilog/sss_ctrl.sv ====
// Sleep and cycle control for a pipelined synchronous SRAM, array included.
// Assumes inputs synchronous to sys_clk; the data pin is split in three.
//
// Overview of operation
// - Sleep behaves as deselected, no array access.
// - Sleep ignores inputs, outputs float.
// - Sleep lasts exactly while request is high.
// - Inputs ignored within one clock of entry.
// - Inputs sampled within one clock of exit.
// - Burst order: zero linear, one interleaved.
// - Single accesses work without burst continuation.
// - Selected only when all three selects agree.
// - Reads always return the newest value.
// - Forward input data register on match.
// - Gated clock edge stalls, no write.
// - Load low decodes write or read.
`timescale 1ns/1ps
`default_nettype none

module sss_ctrl (
  input  wire logic                      sys_clk,
  input  wire logic                      resetn,
  input  wire logic                      sleep_request,
  input  wire logic                      clock_gate_en,
  input  wire logic                      burst_order,
  input  wire sss_pkg::sss_req_t         req,
  input  wire logic [sss_pkg::DATA_W-1:0] data_in,
  output logic      [sss_pkg::DATA_W-1:0] data_out,
  output logic                           data_oe_n,
  output logic                           sleeping
);
  import sss_pkg::*;

  // Array storage, flip-flops addressed by index.
  logic [DATA_W-1:0] mem_q [DEPTH];
  // Address stage: operation and address captured on the edge.
  sss_op_t           op_q;
  logic [ADDR_W-1:0] base_q;     // Burst base address.
  logic [1:0]        bcnt_q;     // Two-bit burst counter.
  logic              order_q;    // Burst order of the running burst.
  // Data stage: the input data register holds the pending write.
  logic              wpend_q;
  logic [ADDR_W-1:0] waddr_q;
  logic [DATA_W-1:0] wdata_q;
  // Read stage.
  logic              rpend_q;
  logic [ADDR_W-1:0] raddr_q;
  logic [DATA_W-1:0] data_out_q;
  logic              oe_n_q;
  logic              sleep_q;

  // Sleep follows pin.
  // The pin acts directly on the gating term, so entry and exit take effect
  // at the very next edge; the registered copy only drives the status port.
  wire awake = ~sleep_request;

  wire selected = ~req.select_low & ~req.extra_select_low &
                  req.extra_select_high;

  // Entry and exit within one edge.
  wire take = clock_gate_en & awake;

  wire load_rd = take & selected & ~req.advance_or_load & req.read_not_write;
  wire load_wr = take & selected & ~req.advance_or_load & ~req.read_not_write;
  // A burst only continues an earlier load, so single accesses are safe.
  wire advance = take & req.advance_or_load & (op_q != SSS_OP_IDLE);
  wire desel   = take & ~req.advance_or_load & ~selected;

  wire [1:0] bnext   = bcnt_q + 2'h1;
  wire [1:0] boffset = (order_q == BURST_INTERLEAVED) ? (base_q[1:0] ^ bnext)
                                                      : (base_q[1:0] + bnext);
  wire [ADDR_W-1:0] adv_addr = {base_q[ADDR_W-1:2], boffset};
  wire [ADDR_W-1:0] cur_addr = load_rd | load_wr ? req.addr : adv_addr;
  wire do_rd = load_rd | (advance & (op_q == SSS_OP_READ));
  wire do_wr = load_wr | (advance & (op_q == SSS_OP_WRITE));

  // Forward input data register.
  // A write still waiting in the input data register wins over the array.
  wire fwd_hit = wpend_q & (waddr_q == raddr_q);
  wire [DATA_W-1:0] rd_value = fwd_hit ? wdata_q : mem_q[raddr_q];

  // Address stage and burst counter.
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      op_q    <= SSS_OP_IDLE;
      base_q  <= ADDR_RST;
      bcnt_q  <= BCNT_RST;
      order_q <= BURST_LINEAR;
    end else if (load_rd | load_wr) begin
      op_q    <= load_rd ? SSS_OP_READ : SSS_OP_WRITE;
      base_q  <= req.addr;
      bcnt_q  <= BCNT_RST;
      order_q <= burst_order;
    end else if (advance) begin
      bcnt_q  <= bnext;
    end else if (desel) begin
      // A deselect ends any burst.
      op_q    <= SSS_OP_IDLE;
    end
  end

  // Write pipeline: address now, data one edge later into the register.
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      wpend_q <= 1'h0;
      waddr_q <= ADDR_RST;
      wdata_q <= DATA_RST;
    end else if (take) begin
      wpend_q <= do_wr;
      if (do_wr) begin
        waddr_q <= cur_addr;
      end
      if (wpend_q) begin
        wdata_q <= data_in;
      end
    end
  end

  // Pending write data arrives with the following enabled edge, so the
  // array commits the value held from the edge before that.
  logic              commit_q;
  logic [ADDR_W-1:0] caddr_q;
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      commit_q <= 1'h0;
      caddr_q  <= ADDR_RST;
    end else if (take) begin
      commit_q <= wpend_q;
      caddr_q  <= waddr_q;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (take && commit_q) begin
      mem_q[caddr_q] <= wdata_q;
    end
  end

  // Read pipeline and output register.
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      rpend_q    <= 1'h0;
      raddr_q    <= ADDR_RST;
      data_out_q <= DATA_RST;
      oe_n_q     <= 1'h1;
    end else if (!awake) begin
      rpend_q    <= 1'h0;
      oe_n_q     <= 1'h1;
    end else if (take) begin
      rpend_q <= do_rd;
      raddr_q <= cur_addr;
      if (rpend_q) begin
        data_out_q <= (commit_q & (caddr_q == raddr_q) & ~fwd_hit)
                      ? wdata_q : rd_value;
      end
      oe_n_q <= ~rpend_q;
    end
  end

  // Sleep status.
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      sleep_q <= 1'h0;
    end else begin
      sleep_q <= sleep_request;
    end
  end

  assign data_out  = data_out_q;
  assign data_oe_n = oe_n_q;
  assign sleeping  = sleep_q;

  // Assertions.
  AST_SLEEP_FLOAT: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    sleep_request |=> data_oe_n)
    else $error("Output driven while asleep.");
  AST_SLEEP_STATUS: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    sleep_request |=> sleeping)
    else $error("Sleep status did not follow request.");
  AST_SLEEP_NOREAD: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    sleep_request |=> !rpend_q)
    else $error("Read launched while asleep.");
  AST_ENTRY_HOLD: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    sleep_request |=> $stable(base_q))
    else $error("Input taken after sleep entry.");
  AST_STALL_HOLD: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    !clock_gate_en |=> $stable(wpend_q) && $stable(bcnt_q))
    else $error("Pipeline moved on a stalled edge.");
  AST_SELECT: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    (load_rd || load_wr) |-> (!req.select_low && !req.extra_select_low &&
                              req.extra_select_high))
    else $error("Load taken while deselected.");
  AST_READ_OUT: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    (load_rd && !sleep_request) ##1 (clock_gate_en && !sleep_request)
    |=> !data_oe_n)
    else $error("Read did not drive output.");
  // A read right behind a write to the same place takes the register value.
  AST_FORWARD: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    (take && rpend_q && (fwd_hit || (commit_q && caddr_q == raddr_q)))
    |=> data_out == $past(wdata_q))
    else $error("Forwarded data wrong.");
  AST_LINEAR: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    (advance && order_q == BURST_LINEAR) |=> bcnt_q == $past(bnext))
    else $error("Burst counter did not advance.");
  AST_WAKE: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    $fell(sleep_request) && clock_gate_en && load_rd |=> rpend_q)
    else $error("Input not sampled after wake.");

  CVR_READ:  cover property (@(posedge sys_clk) load_rd ##2 !data_oe_n);
  CVR_WRITE: cover property (@(posedge sys_clk) load_wr ##1 load_rd);
  CVR_BURST: cover property (@(posedge sys_clk) load_rd ##1 advance);
  CVR_SLEEP: cover property (@(posedge sys_clk) $rose(sleep_request));

endmodule // sss_ctrl

`default_nettype wire

// ==== test/sss_mc_model.sv ====
// Memory controller model driving the request side of the controller.
// Assumes the bench calls its tasks from a single thread.
`timescale 1ns/1ps
`default_nettype none

module sss_mc_model (
  input  wire logic                       sys_clk,
  output var  logic                       sleep_request,
  output var  logic                       clock_gate_en,
  output var  logic                       burst_order,
  output var  sss_pkg::sss_req_t          req,
  output var  logic [sss_pkg::DATA_W-1:0] data_in
);
  import sss_pkg::*;

  // Start awake, honoured and deselected.
  initial begin
    sleep_request = 1'h0;
    clock_gate_en = 1'h1;
    burst_order   = 1'h0;
    req           = '{1'h1, 1'h0, 1'h1, 1'h0, 1'h1, ADDR_RST};
    data_in       = DATA_RST;
  end

  task automatic issue(input logic [2:0] sel, input logic adv, rnw,
      input logic [ADDR_W-1:0] a, input logic gate);
    @(posedge sys_clk);
    req <= '{sel[2], sel[1], sel[0], adv, rnw, a};
    clock_gate_en <= gate;
  endtask

  // A deselect cycle is the safe filler between accesses.
  task automatic idle();
    issue(3'h5, 1'h0, 1'h1, ADDR_RST, 1'h1);
  endtask

  task automatic wr(input logic [2:0] sel, input logic [ADDR_W-1:0] a,
      input logic [DATA_W-1:0] d, input logic gate, fwd);
    issue(sel, 1'h0, 1'h0, a, gate);
    // A read of the same place may follow at once, to test forwarding.
    issue(fwd ? 3'h1 : 3'h5, 1'h0, 1'h1, a, 1'h1);
    data_in <= d;
    idle();
    // Released data shows the inverse, so a stale value never matches.
    data_in <= ~d;
  endtask

  task automatic rd(input logic [2:0] sel, input logic [ADDR_W-1:0] a);
    issue(sel, 1'h0, 1'h1, a, 1'h1);
    idle();
  endtask

  task automatic pins(input logic zz, bo);
    @(posedge sys_clk);
    sleep_request <= zz;
    burst_order <= bo;
  endtask
endmodule // sss_mc_model

`default_nettype wire

// ==== test/tb_top.sv ====
// Self-checking bench for the sleep and cycle controller.
// Assumes the controller model drives every request input.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin checked++; \
  if ((got) !== (exp)) begin errors++; \
    $display("FAIL %s expected %0h seen %0h", nm, exp, got); end end

module tb_top;
  import sss_pkg::*;

  logic              sys_clk = 1'h0;
  logic              resetn = 1'h0;
  logic              sleep_request, clock_gate_en, burst_order;
  logic              data_oe_n, sleeping;
  sss_req_t          req;
  logic [DATA_W-1:0] data_in, data_out, exp_d;
  int                errors = 0;
  int                checked = 0;
  localparam logic [2:0] ACT = 3'h1;

  // A 50 ns period clock.
  always #25 sys_clk = ~sys_clk;

  sss_mc_model u_mc (.sys_clk(sys_clk), .sleep_request(sleep_request),
    .clock_gate_en(clock_gate_en), .burst_order(burst_order),
    .req(req), .data_in(data_in));

  sss_ctrl u_dut (.sys_clk(sys_clk), .resetn(resetn),
    .sleep_request(sleep_request), .clock_gate_en(clock_gate_en),
    .burst_order(burst_order), .req(req), .data_in(data_in),
    .data_out(data_out), .data_oe_n(data_oe_n), .sleeping(sleeping));

  // Read data stands from the edge after the one that takes the load, that
  // is two edges after the load is driven; the access tasks already spend
  // one of them, so one more edge brings the data, and only for one cycle.
  task automatic wait2();
    @(posedge sys_clk);
    #1;
  endtask

  task automatic done(input string nm);
    $display("test %s done", nm);
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic summarize();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // The tests take about 80 cycles; a hang stops at 3000.
  initial begin
    repeat (3000) @(posedge sys_clk);
    errors++;
    summarize();
  end

  initial begin
    repeat (2) @(posedge sys_clk);
    resetn <= 1'h1;
    #1;
    `CHK("oe_n after reset", 1'h1, data_oe_n)
    `CHK("sleeping after reset", 1'h0, sleeping)
    u_mc.wr(ACT, 6'h03, 8'hA5, 1'h1, 1'h1);
    wait2();
    `CHK("forwarded read", 8'hA5, data_out)
    `CHK("read drives", 1'h0, data_oe_n)
    u_mc.rd(ACT, 6'h03);
    wait2();
    `CHK("array read", 8'hA5, data_out)
    done("coherency");
    u_mc.wr(ACT, 6'h09, 8'h66, 1'h1, 1'h0);
    // Every select pattern but the enabled one must be a deselect.
    for (int s = 0; s < 8; s++) begin
      if (s != 1) u_mc.wr(3'(s), 6'h09, 8'(s), 1'h1, 1'h0);
    end
    u_mc.rd(3'h3, 6'h09);
    wait2();
    `CHK("deselected read", 1'h1, data_oe_n)
    u_mc.wr(ACT, 6'h09, 8'h3C, 1'h0, 1'h0);
    u_mc.rd(ACT, 6'h09);
    wait2();
    `CHK("selects and stall", 8'h66, data_out)
    done("select_stall");
    u_mc.pins(1'h1, 1'h0);
    @(posedge sys_clk);
    #1;
    `CHK("asleep flag", 1'h1, sleeping)
    u_mc.wr(ACT, 6'h09, 8'hE1, 1'h1, 1'h0);
    u_mc.rd(ACT, 6'h09);
    wait2();
    `CHK("asleep output floats", 1'h1, data_oe_n)
    // The read load stands over the wake edge, so the first awake edge
    // must take it at once.
    u_mc.issue(ACT, 1'h0, 1'h1, 6'h09, 1'h1);
    u_mc.pins(1'h0, 1'h0);
    u_mc.idle();
    wait2();
    `CHK("awake flag", 1'h0, sleeping)
    `CHK("wake read drives", 1'h0, data_oe_n)
    `CHK("write ignored asleep", 8'h66, data_out)
    done("sleep");
    for (int k = 0; k < 4; k++) begin
      u_mc.wr(ACT, 6'(k), 8'h10 + 8'(k), 1'h1, 1'h0);
    end
    // Both orders, starting at 1 so linear and interleaved differ.
    // Beat n stands from the edge after the one that takes its cycle.
    for (int o = 0; o < 2; o++) begin
      u_mc.pins(1'h0, o[0]);
      u_mc.issue(ACT, 1'h0, 1'h1, 6'h01, 1'h1);
      for (int k = 0; k < 5; k++) begin
        if (k < 3) u_mc.issue(ACT, 1'h1, 1'h1, ADDR_RST, 1'h1);
        else if (k == 3) u_mc.idle();
        else @(posedge sys_clk);
        #1;
        exp_d = 8'h10 + 8'(o[0] ? (k - 1) ^ 1 : k & 3);
        if (k >= 1) `CHK("burst beat", exp_d, data_out)
      end
    end
    done("burst");
    summarize();
  end
endmodule // tb_top

`default_nettype wire
